// file: logic/irsir_endec.sv
// serial infrared 3/16 pulse encoder and pulse stretching decoder
`timescale 1ns/1ps
module irsir_endec (
  input  wire logic                    i_clk,
  input  wire logic                    i_sys_rst,
  input  wire logic                    i_txd,
  input  wire logic                    i_ext_bclk,
  input  wire logic                    i_use_ext_bclk,
  input  wire logic [2:0]              i_rate_sel,
  input  wire logic                    i_fixed_pulse,
  input  wire logic                    i_ir_pulse_in_n,
  input  wire irsir_pkg::irsir_pwr_t   i_pwr_sel,
  output logic                         o_ir_pulse_out,
  output logic                         o_rxd,
  output logic                         o_tick,
  output irsir_pkg::irsir_mode_pins_t  o_mode
);
  irsir_pkg::irsir_state_t s_q;
  irsir_pkg::irsir_state_t s_d;
  logic [irsir_pkg::DIV_W-1:0] div_lim;
  logic                        tick_now;
  logic                        fixed_ok;

  // =========================================================
  // tick rate select
  always_comb begin
    case (irsir_pkg::irsir_rate_t'(i_rate_sel))
      irsir_pkg::IRSIR_R9600:   div_lim = irsir_pkg::DIV_9600;
      irsir_pkg::IRSIR_R19200:  div_lim = irsir_pkg::DIV_19200;
      irsir_pkg::IRSIR_R38400:  div_lim = irsir_pkg::DIV_38400;
      irsir_pkg::IRSIR_R57600:  div_lim = irsir_pkg::DIV_57600;
      irsir_pkg::IRSIR_R115200: div_lim = irsir_pkg::DIV_115200;
      default:                  div_lim = irsir_pkg::DIV_9600;
    endcase
  end

  // fixed width pulses only below the top rate
  assign fixed_ok = i_fixed_pulse && (i_rate_sel != 3'(irsir_pkg::IRSIR_R115200));

  // external 16x clock: rising edge of the stable sampled level
  // internal: >= so a smaller limit picked mid-count ends the period at once instead of wrapping
  assign tick_now = i_use_ext_bclk ? (s_q.sync_bclk[2] == s_q.sync_bclk[1] && s_q.sync_bclk[1] && !s_q.bclk_stable)
                                   : (s_q.div_cnt >= div_lim - 10'h001);

  // =========================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.sync_tx   = {s_q.sync_tx[1:0], i_txd};
    s_d.sync_rx   = {s_q.sync_rx[1:0], i_ir_pulse_in_n};
    s_d.sync_bclk = {s_q.sync_bclk[1:0], i_ext_bclk};
    if (s_q.sync_tx[2] == s_q.sync_tx[1]) begin
      s_d.txd_stable = s_q.sync_tx[2];
    end
    if (s_q.sync_rx[2] == s_q.sync_rx[1]) begin
      s_d.rx_stable = s_q.sync_rx[2];
    end
    if (s_q.sync_bclk[2] == s_q.sync_bclk[1]) begin
      s_d.bclk_stable = s_q.sync_bclk[2];
    end
    s_d.div_cnt = (tick_now || i_use_ext_bclk) ? '0 : s_q.div_cnt + 10'h001;
    s_d.tick    = tick_now;

    // encoder: a bit starts on the first tick that finds the stable txd low
    if (s_q.fix_cnt != 8'h00) begin
      s_d.fix_cnt = s_q.fix_cnt - 8'h01;
    end
    case (s_q.tx_st)
      irsir_pkg::IRSIR_TX_IDLE: begin
        s_d.ir_out = 1'b0;
        if (s_q.tick && !s_q.txd_stable) begin
          s_d.tx_st   = irsir_pkg::IRSIR_TX_PULSE;
          s_d.tx_cnt  = 4'h0;
          s_d.ir_out  = 1'b1;
          s_d.fix_cnt = irsir_pkg::FIXED_CYC - 8'h01;
        end
      end
      irsir_pkg::IRSIR_TX_PULSE: begin
        if (fixed_ok) begin
          if (s_q.fix_cnt == 8'h00) begin
            s_d.ir_out = 1'b0;
          end
        end else if (s_q.tick && s_q.tx_cnt == irsir_pkg::PULSE_LAST) begin
          s_d.ir_out = 1'b0;
        end
        if (s_q.tick) begin
          s_d.tx_cnt = s_q.tx_cnt + 4'h1;
          if (s_q.tx_cnt == irsir_pkg::PULSE_LAST) begin
            s_d.tx_st = irsir_pkg::IRSIR_TX_REST;
          end
        end
      end
      irsir_pkg::IRSIR_TX_REST: begin
        if (fixed_ok && s_q.fix_cnt == 8'h00) begin
          s_d.ir_out = 1'b0;
        end else if (!fixed_ok) begin
          s_d.ir_out = 1'b0;
        end
        if (s_q.tick) begin
          s_d.tx_cnt = s_q.tx_cnt + 4'h1;
          if (s_q.tx_cnt == irsir_pkg::TICK_LAST) begin
            s_d.tx_st = irsir_pkg::IRSIR_TX_IDLE;
            if (!s_q.txd_stable) begin
              // next bit is also zero: start its pulse on this tick
              s_d.tx_st   = irsir_pkg::IRSIR_TX_PULSE;
              s_d.tx_cnt  = 4'h0;
              s_d.ir_out  = 1'b1;
              s_d.fix_cnt = irsir_pkg::FIXED_CYC - 8'h01;
            end
          end
        end
      end
      default: begin
        s_d.tx_st  = irsir_pkg::IRSIR_TX_IDLE;
        s_d.ir_out = 1'b0;
      end
    endcase

    // decoder: active low pulse in, stretched low bit out
    if (!s_q.rx_busy && !s_q.rx_stable) begin
      s_d.rx_busy = 1'b1;
      s_d.rx_cnt  = 4'h0;
      s_d.rxd     = 1'b0;
    end else if (s_q.rx_busy && s_q.tick) begin
      s_d.rx_cnt = s_q.rx_cnt + 4'h1;
      if (s_q.rx_cnt == irsir_pkg::TICK_LAST) begin
        s_d.rx_busy = 1'b0;
        s_d.rxd     = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s_q <= '{div_cnt: '0, tick: 1'b0, sync_tx: 3'h7, sync_rx: 3'h7, sync_bclk: 3'h0,
               txd_stable: 1'b1, rx_stable: 1'b1, bclk_stable: 1'b0,
               tx_st: irsir_pkg::IRSIR_TX_IDLE, tx_cnt: 4'h0, fix_cnt: 8'h00,
               ir_out: 1'b0, rx_busy: 1'b0, rx_cnt: 4'h0, rxd: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_ir_pulse_out = s_q.ir_out;
  assign o_rxd          = s_q.rxd;
  assign o_tick         = s_q.tick;

  // =========================================================
  // power mode pins
  irsir_pwr_mode u_pwr (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_pwr_sel (i_pwr_sel),
    .o_mode    (o_mode)
  );

  // =========================================================
  // checks
  a_idle_dark: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s_q.tx_st == irsir_pkg::IRSIR_TX_IDLE) |-> !o_ir_pulse_out)
    else $error("emitter on while idle");
  a_pulse_rise: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s_q.tx_st == irsir_pkg::IRSIR_TX_IDLE && s_q.tick && !s_q.txd_stable) |=> o_ir_pulse_out)
    else $error("pulse not started on zero bit");
  a_pulse_end: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!fixed_ok && s_q.tx_st == irsir_pkg::IRSIR_TX_PULSE && s_q.tick && s_q.tx_cnt == irsir_pkg::PULSE_LAST)
    |=> !o_ir_pulse_out)
    else $error("3/16 pulse did not end after three ticks");
  a_no_nrz: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s_q.tx_st == irsir_pkg::IRSIR_TX_REST && !fixed_ok) |-> !o_ir_pulse_out)
    else $error("emitter on past the pulse slot");
  a_fixed_width: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (fixed_ok && s_q.fix_cnt == 8'h00 && s_q.tx_st != irsir_pkg::IRSIR_TX_IDLE && s_q.tick == 1'b0
     && !(s_q.tx_st == irsir_pkg::IRSIR_TX_REST && s_q.tx_cnt == irsir_pkg::TICK_LAST))
    |=> !o_ir_pulse_out)
    else $error("fixed pulse too long");
  a_rx_stretch: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s_q.rx_busy && s_q.tick && s_q.rx_cnt == irsir_pkg::TICK_LAST) |=> (o_rxd && !s_q.rx_busy))
    else $error("stretched bit did not end after sixteen ticks");
  a_rx_start: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!s_q.rx_busy && !s_q.rx_stable) |=> !o_rxd)
    else $error("received pulse not stretched");
  a_base_rate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!i_use_ext_bclk && i_rate_sel == 3'h0 && o_tick) |=> (!o_tick) [*8])
    else $error("startup tick too fast");

  c_zero_bit: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(o_ir_pulse_out));
  c_rx_bit: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(o_rxd));
  c_fixed: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    fixed_ok && $fell(o_ir_pulse_out));
  c_ext_clk: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    i_use_ext_bclk && o_tick);
endmodule : irsir_endec

// file: logic/irsir_pkg.sv
// package of constants and carriers for the serial infrared pulse endec
package irsir_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned BASE_BAUD       = 9600;
  localparam int unsigned TICKS_PER_BIT   = 16;
  localparam int unsigned BASE_TICK_HZ    = 153600;
  localparam int unsigned PULSE_TICKS     = 3;
  localparam int unsigned FIXED_PULSE_NS  = 1600;
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned FIXED_PULSE_CYC = FIXED_PULSE_NS / CLK_PERIOD_NS;
  localparam logic [3:0]  TICK_LAST       = 4'hf;
  localparam logic [3:0]  PULSE_LAST      = 4'h2;
  localparam logic [3:0]  MID_BIT         = 4'h7;
  localparam logic [7:0]  FIXED_CYC       = 8'(FIXED_PULSE_CYC);
  localparam int unsigned DIV_W           = 10;
  // divider per rate code: 100 MHz / (16 * baud), rounded down
  localparam logic [DIV_W-1:0] DIV_9600   = 10'(CLK_HZ / BASE_TICK_HZ);
  localparam logic [DIV_W-1:0] DIV_19200  = 10'(CLK_HZ / (16 * 19200));
  localparam logic [DIV_W-1:0] DIV_38400  = 10'(CLK_HZ / (16 * 38400));
  localparam logic [DIV_W-1:0] DIV_57600  = 10'(CLK_HZ / (16 * 57600));
  localparam logic [DIV_W-1:0] DIV_115200 = 10'(CLK_HZ / (16 * 115200));

  typedef enum logic [2:0] {
    IRSIR_R9600   = 3'h0,
    IRSIR_R19200  = 3'h1,
    IRSIR_R38400  = 3'h2,
    IRSIR_R57600  = 3'h3,
    IRSIR_R115200 = 3'h4
  } irsir_rate_t;

  typedef enum logic [1:0] {
    IRSIR_PWR_FULL  = 2'h0,
    IRSIR_PWR_TWO3  = 2'h1,
    IRSIR_PWR_ONE3  = 2'h2,
    IRSIR_PWR_SHUT  = 2'h3
  } irsir_pwr_t;

  // mode pin pair: mode0 first, mode1 second
  typedef struct packed {
    logic mode0;
    logic mode1;
  } irsir_mode_pins_t;

  typedef enum logic [1:0] {
    IRSIR_TX_IDLE  = 2'h0,
    IRSIR_TX_PULSE = 2'h1,
    IRSIR_TX_REST  = 2'h3
  } irsir_tx_st_t;

  typedef struct packed {
    logic [DIV_W-1:0] div_cnt;
    logic             tick;
    logic [2:0]       sync_tx;
    logic [2:0]       sync_rx;
    logic [2:0]       sync_bclk;
    logic             txd_stable;
    logic             rx_stable;
    logic             bclk_stable;
    irsir_tx_st_t     tx_st;
    logic [3:0]       tx_cnt;
    logic [7:0]       fix_cnt;
    logic             ir_out;
    logic             rx_busy;
    logic [3:0]       rx_cnt;
    logic             rxd;
  } irsir_state_t;
endpackage : irsir_pkg

// file: logic/irsir_pwr_mode.sv
// transmit power mode pin encoder
`timescale 1ns/1ps
module irsir_pwr_mode (
  input  wire logic                       i_clk,
  input  wire logic                       i_sys_rst,
  input  wire irsir_pkg::irsir_pwr_t      i_pwr_sel,
  output irsir_pkg::irsir_mode_pins_t     o_mode
);
  irsir_pkg::irsir_mode_pins_t mode_d;
  irsir_pkg::irsir_mode_pins_t mode_q;

  always_comb begin
    case (i_pwr_sel)
      irsir_pkg::IRSIR_PWR_SHUT: mode_d = '{mode0: 1'b1, mode1: 1'b0};
      irsir_pkg::IRSIR_PWR_FULL: mode_d = '{mode0: 1'b0, mode1: 1'b0};
      irsir_pkg::IRSIR_PWR_TWO3: mode_d = '{mode0: 1'b0, mode1: 1'b1};
      irsir_pkg::IRSIR_PWR_ONE3: mode_d = '{mode0: 1'b1, mode1: 1'b1};
      default:                   mode_d = '{mode0: 1'b0, mode1: 1'b0};
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mode_q <= '{mode0: 1'b0, mode1: 1'b0};
    end else begin
      mode_q <= mode_d;
    end
  end

  assign o_mode = mode_q;

  a_shut_code: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_pwr_sel == irsir_pkg::IRSIR_PWR_SHUT |=> (o_mode.mode0 && !o_mode.mode1))
    else $error("shutdown mode pins wrong");
  a_third_code: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_pwr_sel == irsir_pkg::IRSIR_PWR_ONE3 |=> (o_mode.mode0 && o_mode.mode1))
    else $error("one third mode pins wrong");
  a_twothird_code: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_pwr_sel == irsir_pkg::IRSIR_PWR_TWO3 |=> (!o_mode.mode0 && o_mode.mode1))
    else $error("two third mode pins wrong");
endmodule : irsir_pwr_mode

// file: tb/irsir_xcvr_model.sv
// infrared transceiver model: counts emitter flashes and returns detector pulses
`timescale 1ns/1ps
module irsir_xcvr_model #(
  parameter int RX_W = 150
) (
  input  wire logic i_clk,
  input  wire logic i_led,
  input  wire logic i_light,
  output logic      o_rx_n,
  output int        o_led_count
);
  int   rx_left = 0;
  logic light_q = 1'b0;
  logic led_q   = 1'b0;

  initial o_led_count = 0;

  // one short active low pulse per incoming flash, whatever its width
  always @(posedge i_clk) begin
    light_q <= i_light;
    led_q   <= i_led;
    if (i_led && !led_q) begin
      o_led_count <= o_led_count + 1;
    end
    if (i_light && !light_q) begin
      rx_left <= RX_W;
    end else if (rx_left > 0) begin
      rx_left <= rx_left - 1;
    end
  end

  // detector idles high between pulses
  assign o_rx_n = (rx_left == 0);
endmodule : irsir_xcvr_model

// file: tb/tb_irsir_endec.sv
// self-checking bench for the infrared pulse endec
`timescale 1ns/1ps
module tb_irsir_endec;
  logic                        clk        = 1'b0;
  logic                        rst        = 1'b1;
  logic                        txd        = 1'b1;
  logic                        ext_bclk   = 1'b0;
  logic                        ext_on     = 1'b0;
  logic                        use_ext    = 1'b0;
  logic [2:0]                  rate       = 3'h0;
  logic                        fixed      = 1'b0;
  logic                        light      = 1'b0;
  irsir_pkg::irsir_pwr_t       pwr        = irsir_pkg::IRSIR_PWR_FULL;
  logic                        ir_out;
  logic                        rxd;
  logic                        tick;
  logic                        rx_n;
  irsir_pkg::irsir_mode_pins_t mode;
  int                          led_count;
  int                          bad_count  = 0;
  int                          n_compared = 0;

  always #5 clk = ~clk;
  // external 16x clock, 40 cycles per period, edges on falling clock edges
  always #200 if (ext_on) ext_bclk = ~ext_bclk;

  irsir_endec u_irsir_endec (
    .i_clk           (clk),
    .i_sys_rst       (rst),
    .i_txd           (txd),
    .i_ext_bclk      (ext_bclk),
    .i_use_ext_bclk  (use_ext),
    .i_rate_sel      (rate),
    .i_fixed_pulse   (fixed),
    .i_ir_pulse_in_n (rx_n),
    .i_pwr_sel       (pwr),
    .o_ir_pulse_out  (ir_out),
    .o_rxd           (rxd),
    .o_tick          (tick),
    .o_mode          (mode)
  );

  irsir_xcvr_model u_irsir_xcvr_model (
    .i_clk       (clk),
    .i_led       (ir_out),
    .i_light     (light),
    .o_rx_n      (rx_n),
    .o_led_count (led_count)
  );

  // ==========================================
  // checking and bounded waits
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // sel 0 tick, 1 emitter, 2 decoded data; n counts falling edges waited
  task automatic wait_for(input int sel, input logic lvl, input int bound, output int n);
    logic v;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      v = (sel == 0) ? tick : (sel == 1) ? ir_out : rxd;
      if (n > bound) begin
        check("wait bound", 32'h1, 32'h0);
        wrap_up();
      end
    end while (v !== lvl);
  endtask : wait_for

  // ==========================================
  // scenarios
  task automatic t_reset();
    check("ir out in reset", 32'(ir_out), 32'h0);
    check("rxd in reset", 32'(rxd), 32'h1);
    check("mode in reset", 32'(mode), 32'h0);
  endtask : t_reset

  task automatic t_rates();
    logic [9:0] d [6] = '{irsir_pkg::DIV_9600, irsir_pkg::DIV_19200, irsir_pkg::DIV_38400,
                          irsir_pkg::DIV_57600, irsir_pkg::DIV_115200, irsir_pkg::DIV_9600};
    int n;
    for (int r = 0; r < 6; r++) begin
      rate = 3'(r);
      wait_for(0, 1'b1, 2000, n);
      wait_for(0, 1'b1, 2000, n);
      wait_for(0, 1'b1, 2000, n);
      check("tick period", 32'(n), 32'(d[r]));
    end
  endtask : t_rates

  task automatic t_ext();
    int n;
    use_ext = 1'b1;
    ext_on  = 1'b1;
    wait_for(0, 1'b1, 2000, n);
    wait_for(0, 1'b1, 200, n);
    wait_for(0, 1'b1, 200, n);
    check("ext tick period", 32'(n), 32'h28);
    ext_on  = 1'b0;
    use_ext = 1'b0;
  endtask : t_ext

  task automatic t_enc(input logic [2:0] r, input logic f, input int per, input int exp_w);
    int n;
    int w;
    int c0;
    rate  = r;
    fixed = f;
    wait_for(0, 1'b1, 2000, n);
    wait_for(0, 1'b1, 2000, n);
    txd = 1'b0;
    wait_for(1, 1'b1, 20 * per, n);
    wait_for(1, 1'b0, 20 * per, w);
    check("pulse width", 32'(w), 32'(exp_w));
    wait_for(1, 1'b1, 20 * per, n);
    check("zero bit spacing", 32'(w + n), 32'(16 * per));
    txd = 1'b1;
    @(negedge clk);
    c0 = led_count;
    repeat (20 * per) @(negedge clk);
    check("pulses for one bits", 32'(led_count - c0), 32'h0);
    fixed = 1'b0;
  endtask : t_enc

  task automatic t_dec();
    int per;
    int n;
    int w;
    per   = int'(irsir_pkg::DIV_115200);
    rate  = 3'h4;
    light = 1'b1;
    @(negedge clk);
    light = 1'b0;
    wait_for(2, 1'b0, 100, n);
    w = 0;
    // a second flash inside the stretched bit must not restart it
    while (rxd === 1'b0 && w < 2000) begin
      light = (w == 400);
      @(negedge clk);
      w++;
    end
    // a tick in the start cycle is not counted, so the bit may last up to sixteen full tick periods
    check("rx bit width", 32'(w > 15 * per && w <= 16 * per + 1), 32'h1);
    n = 0;
    repeat (3 * per) begin
      @(negedge clk);
      n += (rxd !== 1'b1);
    end
    check("rx after bit", 32'(n), 32'h0);
  endtask : t_dec

  task automatic t_pwr();
    logic [1:0] exp [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    for (int i = 0; i < 4; i++) begin
      pwr = irsir_pkg::irsir_pwr_t'(i);
      repeat (2) @(negedge clk);
      check("mode pins", 32'(mode), 32'(exp[i]));
    end
  endtask : t_pwr

  // ==========================================
  // main sequence
  initial begin
    repeat (12) @(negedge clk);
    t_reset();
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_rates();
    t_ext();
    t_enc(3'h4, 1'b0, int'(irsir_pkg::DIV_115200), 3 * int'(irsir_pkg::DIV_115200));
    t_enc(3'h3, 1'b1, int'(irsir_pkg::DIV_57600), int'(irsir_pkg::FIXED_PULSE_CYC));
    t_enc(3'h4, 1'b1, int'(irsir_pkg::DIV_115200), 3 * int'(irsir_pkg::DIV_115200));
    t_enc(3'h0, 1'b0, int'(irsir_pkg::DIV_9600), 3 * int'(irsir_pkg::DIV_9600));
    t_dec();
    t_pwr();
    wrap_up();
  end
endmodule : tb_irsir_endec
